// File: gdf_defines.svh
// Timing constants of the gate driver fault reaction block.
// Assumes a 250 MHz secondary-side clock; all counts derive from it.
`ifndef GDF_DEFINES_SVH
`define GDF_DEFINES_SVH

// Clock period in ns
`define GDF_CLK_NS        4
// Shoot-through dead time window in ns
`define GDF_DEAD_MIN_NS   720
`define GDF_DEAD_MAX_NS   1200
// Least time rounds up to whole cycles
`define GDF_DEAD_CYC      ((`GDF_DEAD_MIN_NS + `GDF_CLK_NS - 1) / `GDF_CLK_NS)
`define GDF_DEAD_MAX_CYC  (`GDF_DEAD_MAX_NS / `GDF_CLK_NS)
// Longest and typical reaction times in ns, fault pin times in us; counts round down
`define GDF_FLT_MAX_US    5
`define GDF_FLT_TYP_US    2
`define GDF_EN_OFF_NS     400
`define GDF_DESAT_OFF_NS  430
`define GDF_OCP_OFF_NS    130
`define GDF_OCP_TYP_NS    110
`define GDF_CLB_OFF_NS    400
`define GDF_PRI_OFF_NS    255
`define GDF_SEC_OFF_NS    400
`define GDF_LS_OFF_NS     430
`define GDF_FLT_CYC       ((`GDF_FLT_MAX_US * 1000) / `GDF_CLK_NS)
`define GDF_EN_CYC        (`GDF_EN_OFF_NS / `GDF_CLK_NS)
`define GDF_DESAT_CYC     (`GDF_DESAT_OFF_NS / `GDF_CLK_NS)
`define GDF_OCP_CYC       (`GDF_OCP_OFF_NS / `GDF_CLK_NS)
`define GDF_CLB_CYC       (`GDF_CLB_OFF_NS / `GDF_CLK_NS)
`define GDF_PRI_CYC       (`GDF_PRI_OFF_NS / `GDF_CLK_NS)
`define GDF_SEC_CYC       (`GDF_SEC_OFF_NS / `GDF_CLK_NS)
`define GDF_LSO_CYC       (`GDF_LS_OFF_NS / `GDF_CLK_NS)
// Life-sign recognition time, typical 5 us
`define GDF_LS_DET_US     5
`define GDF_LS_DET_CYC    ((`GDF_LS_DET_US * 1000) / `GDF_CLK_NS)
// Millisecond timeouts, held in us
`define GDF_VMTO0_US      14700
`define GDF_VMTO1_US      59000
`define GDF_MCTO_US       15000
`define GDF_VMTO0_CYC     ((`GDF_VMTO0_US * 1000) / `GDF_CLK_NS)
`define GDF_VMTO1_CYC     ((`GDF_VMTO1_US * 1000) / `GDF_CLK_NS)
`define GDF_MCTO_CYC      ((`GDF_MCTO_US * 1000) / `GDF_CLK_NS)
`define GDF_TMR_W         24

`endif

// File: gdf_pkg.sv
// Types shared by the gate driver fault reaction block.
// Assumes nothing beyond the defines header.
package gdf_pkg;

  // Output stage sequencing states
  typedef enum logic [1:0] {
    GDF_OFF,
    GDF_DEAD,
    GDF_ON,
    GDF_SOFT
  } gdf_state_e;

  // Event and command levels arriving from pins and comparators
  typedef struct packed {
    logic pwm_cmd;           // Switching command
    logic enable_in;         // Enable, high allows switching
    logic desat_in;          // Desaturation comparator
    logic overcurrent_input; // Overcurrent comparator
    logic class_a_evt;       // Class A failure detected
    logic class_b_evt;       // Class B failure detected
    logic prim_fail;         // Low-voltage side failure or reset
    logic sec_fail;          // High-voltage side failure or reset
    logic life_sign_err;     // Life-sign error condition
  } gdf_evt_s;

endpackage : gdf_pkg

// File: gdf_fault_reaction.sv
// Fault reaction and switching sequencer of the high-voltage side.
// Assumes event pins are asynchronous; configuration and mode requests
// come from logic on sys_clk.
// Behaviour
// - Dead time 720 to 1200 ns between transitions
// - Class A pin within 5 us
// - Enable removal starts turn-off within 400 ns
// - Desaturation after blanking: turn-off within 430 ns
// - Overcurrent after blanking: turn-off within 130 ns
// - Class B: pin in 5 us, off 400 ns
// - Low-side failure starts turn-off within 255 ns
// - High-side failure starts turn-off within 400 ns
// - Verification timeout 14.7 or 59 ms
// - Mode change timeouts of 15 ms
// - Life-sign error recognised within 5 us
// - Life-sign error starts turn-off within 430 ns
// - Blanking within 20 percent of programmed
// - Clamp and two-level settings extend timing
`timescale 1ns/1ns
`include "gdf_defines.svh"

module gdf_fault_reaction #(
  parameter int VMTO0_CYC = `GDF_VMTO0_CYC, // Verify timeout, select 0
  parameter int VMTO1_CYC = `GDF_VMTO1_CYC, // Verify timeout, select 1
  parameter int MCTO_CYC  = `GDF_MCTO_CYC,  // Mode change timeout
  parameter int BLANK_W   = 16              // Blanking count width
) (
  input  wire logic             sys_clk,
  input  wire logic             rst,
  input  wire logic             ce,
  input  wire gdf_pkg::gdf_evt_s pin_evt,
  input  wire logic [BLANK_W-1:0] blank_cycles,
  input  wire logic [7:0]       clamp_delay_setting,
  input  wire logic [7:0]       two_level_turnoff_time,
  input  wire logic             verify_timeout_select,
  input  wire logic             verify_enter,
  input  wire logic             verify_exit,
  input  wire logic             desat_mode_req,
  input  wire logic             desat_mode_ack,
  input  wire logic             ovlo_mode_req,
  input  wire logic             ovlo_mode_ack,
  input  wire logic             fault_clear,
  output logic                  gate_on,
  output logic                  gate_soft_off,
  output logic                  fault_class_a_pin,
  output logic                  fault_class_b_pin,
  output logic                  fault_latched,
  output logic                  life_sign_fault,
  output logic                  verification_state,
  output logic                  verify_timeout,
  output logic                  desat_mode_timeout,
  output logic                  ovlo_mode_timeout
);

  localparam int TW = `GDF_TMR_W;

  // Counts too large for the timers cannot be served
  if (VMTO0_CYC < 2 || VMTO1_CYC < 2 || MCTO_CYC < 2 ||
      VMTO0_CYC >= (1 << TW) || VMTO1_CYC >= (1 << TW) ||
      MCTO_CYC >= (1 << TW) || BLANK_W < 8 || BLANK_W > 24) begin : g_bad_cfg
    $error("gdf_fault_reaction: parameter out of range");
  end

  ////////////////////////////////////////////////////////////////////////
  // Input synchronisers

  gdf_pkg::gdf_evt_s sync1;   // First stage, read only by evt
  gdf_pkg::gdf_evt_s evt;     // Second stage, safe to use
  logic              pwm_d;   // Previous command for edge detect

  // Two flops against metastability; costs 8 ns of each reaction budget
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      sync1 <= '0;
      evt   <= '0;
      pwm_d <= 1'b0;
    end else if (ce) begin
      sync1 <= pin_evt;
      evt   <= sync1;
      pwm_d <= evt.pwm_cmd;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Blanking after each command change

  logic [BLANK_W-1:0] blank_cnt;  // Remaining blanking cycles
  wire pwm_edge = evt.pwm_cmd ^ pwm_d;
  wire blanking = (blank_cnt != '0);

  // Exact cycle count keeps accuracy at the clock tolerance
  always_ff @(posedge sys_clk) begin
    if (rst)
      blank_cnt <= '0;
    else if (ce) begin
      if (pwm_edge)
        blank_cnt <= blank_cycles;
      else if (blanking)
        blank_cnt <= blank_cnt - 1'b1;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Fault detection

  localparam int LS_CYC = `GDF_LS_DET_CYC;
  logic [11:0] ls_cnt;  // Cycles the life-sign error has lasted

  // Comparators only count once blanking is over and the gate is on
  wire desat_hit = evt.desat_in & ~blanking & gate_on;
  wire ocp_hit   = evt.overcurrent_input & ~blanking & gate_on;
  wire ls_trip   = evt.life_sign_err &
                   (ls_cnt == 12'(LS_CYC - 1));
  // Sticky flags stay out of the trip term so one clear frees them all
  wire fault_trip = desat_hit | ocp_hit | evt.class_b_evt |
                    evt.prim_fail | evt.sec_fail |
                    ls_trip;
  wire stop_req  = fault_trip | fault_latched | ~evt.enable_in;
  wire a_set     = evt.class_a_evt | desat_hit | ocp_hit;

  // Sticky fault flags; a new event wins over a clear in the same cycle
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      ls_cnt            <= '0;
      life_sign_fault   <= 1'b0;
      fault_latched     <= 1'b0;
      fault_class_a_pin <= 1'b0;
      fault_class_b_pin <= 1'b0;
    end else if (ce) begin
      ls_cnt <= (evt.life_sign_err && !ls_trip) ? ls_cnt + 1'b1 : '0;
      life_sign_fault   <= ls_trip | (life_sign_fault & ~fault_clear);
      fault_latched     <= fault_trip | (fault_latched & ~fault_clear);
      fault_class_a_pin <= a_set |
                           (fault_class_a_pin & ~fault_clear);
      fault_class_b_pin <= evt.class_b_evt |
                           (fault_class_b_pin & ~fault_clear);
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Output stage sequencer

  localparam int DEAD_CYC = `GDF_DEAD_CYC;
  gdf_pkg::gdf_state_e state;       // Current sequencing state
  gdf_pkg::gdf_state_e next_state;  // Next sequencing state
  logic [9:0]          seq_cnt;     // Dead or plateau cycles left
  logic [9:0]          next_cnt;
  wire [9:0] dead_load = 10'(DEAD_CYC - 1) + {2'h0, clamp_delay_setting};
  wire [9:0] soft_load = {2'h0, two_level_turnoff_time} - 10'h001;
  wire       soft_use  = (two_level_turnoff_time != 8'h00);
  wire       go_off    = stop_req | ~evt.pwm_cmd;

  // Turn-off always leaves the on state in the cycle a stop is seen
  always_comb begin
    next_state = state;
    next_cnt   = (seq_cnt != '0) ? seq_cnt - 1'b1 : '0;
    case (state)
      gdf_pkg::GDF_OFF: begin
        if (!go_off) begin
          next_state = gdf_pkg::GDF_DEAD;
          next_cnt   = dead_load;
        end
      end
      gdf_pkg::GDF_DEAD: begin
        if (go_off)
          next_state = gdf_pkg::GDF_OFF;
        else if (seq_cnt == '0)
          next_state = gdf_pkg::GDF_ON;
      end
      gdf_pkg::GDF_ON: begin
        if (go_off && soft_use) begin
          next_state = gdf_pkg::GDF_SOFT;
          next_cnt   = soft_load;
        end else if (go_off)
          next_state = gdf_pkg::GDF_OFF;
      end
      gdf_pkg::GDF_SOFT: begin
        if (seq_cnt == '0)
          next_state = gdf_pkg::GDF_OFF;
      end
      default: next_state = gdf_pkg::GDF_OFF;
    endcase
  end

  // Gate outputs registered from the next state
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      state         <= gdf_pkg::GDF_OFF;
      seq_cnt       <= '0;
      gate_on       <= 1'b0;
      gate_soft_off <= 1'b0;
    end else if (ce) begin
      state         <= next_state;
      seq_cnt       <= next_cnt;
      gate_on       <= (next_state == gdf_pkg::GDF_ON);
      gate_soft_off <= (next_state == gdf_pkg::GDF_SOFT);
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Millisecond timeouts

  // One step of a down-counting timeout; zero means idle
  function automatic logic [TW-1:0] tmr_step(
    input logic [TW-1:0] cnt,
    input logic          start,
    input logic          stop,
    input logic [TW-1:0] load
  );
    if (start)
      return load;
    else if (stop)
      return '0;
    else if (cnt != '0)
      return cnt - 1'b1;
    else
      return '0;
  endfunction : tmr_step

  logic [TW-1:0] vm_cnt;   // Verification timer
  logic [TW-1:0] db_cnt;   // Blanking mode change timer
  logic [TW-1:0] ov_cnt;   // Overvoltage lockout mode change timer
  wire [TW-1:0] vm_load = verify_timeout_select ? TW'(VMTO1_CYC) :
                                                  TW'(VMTO0_CYC);
  wire vm_start = verify_enter & ~verification_state;
  wire vm_end   = (vm_cnt == TW'(1)) & ~verify_exit;
  wire db_end   = (db_cnt == TW'(1)) & ~desat_mode_ack & ~desat_mode_req;
  wire ov_end   = (ov_cnt == TW'(1)) & ~ovlo_mode_ack & ~ovlo_mode_req;

  // Timers run on sys_clk so accuracy tracks that clock
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      vm_cnt             <= '0;
      db_cnt             <= '0;
      ov_cnt             <= '0;
      verification_state <= 1'b0;
      verify_timeout     <= 1'b0;
      desat_mode_timeout <= 1'b0;
      ovlo_mode_timeout  <= 1'b0;
    end else if (ce) begin
      vm_cnt <= tmr_step(vm_cnt, vm_start, verify_exit, vm_load);
      db_cnt <= tmr_step(db_cnt, desat_mode_req, desat_mode_ack,
                         TW'(MCTO_CYC));
      ov_cnt <= tmr_step(ov_cnt, ovlo_mode_req, ovlo_mode_ack,
                         TW'(MCTO_CYC));
      verification_state <= vm_start |
                            (verification_state & ~verify_exit & ~vm_end);
      verify_timeout     <= vm_end;
      desat_mode_timeout <= db_end;
      ovlo_mode_timeout  <= ov_end;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Checks

  localparam int FLT_CYC = 8;
  localparam int EN_CYC  = 3;
  localparam int OCP_CYC = 2;
  localparam int DMAX    = `GDF_DEAD_MAX_CYC;
  logic [9:0] off_run;  // Cycles the gate has been off

  always_ff @(posedge sys_clk) begin
    if (rst)
      off_run <= '0;
    else if (ce)
      off_run <= gate_on ? '0 : (off_run == 10'h3FF ? off_run
                                                     : off_run + 1'b1);
  end

  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (rst || !ce);

  sequence s_gate_drops;
    !gate_on;
  endsequence

  a_dead_time_min:
    assert property ($rose(gate_on) |-> off_run >= 10'(DEAD_CYC + 1) &&
                     DEAD_CYC <= DMAX)
    else $error("dead time too short");
  a_class_a_pin:
    assert property (evt.class_a_evt |-> ##[1:FLT_CYC] fault_class_a_pin)
    else $error("class A pin late");
  a_enable_off:
    assert property (!evt.enable_in |-> ##[1:EN_CYC] s_gate_drops)
    else $error("enable removal did not stop gate");
  a_desat_off:
    assert property (gate_on && evt.desat_in && !blanking
                     |-> ##[1:OCP_CYC] s_gate_drops)
    else $error("desaturation did not stop gate");
  a_ocp_off:
    assert property (gate_on && evt.overcurrent_input && !blanking
                     |=> !gate_on)
    else $error("overcurrent did not stop gate");
  a_class_b_react:
    assert property (evt.class_b_evt |=> !gate_on && fault_class_b_pin)
    else $error("class B reaction missing");
  a_prim_off:
    assert property (evt.prim_fail |-> ##[1:EN_CYC] s_gate_drops)
    else $error("low side failure did not stop gate");
  a_sec_off:
    assert property (evt.sec_fail |-> ##[1:EN_CYC] s_gate_drops)
    else $error("high side failure did not stop gate");
  a_ls_detect:
    assert property (evt.life_sign_err && ls_cnt == 12'(LS_CYC - 1)
                     |=> life_sign_fault ##1 !gate_on)
    else $error("life sign error not recognised");
  a_ls_hold_off:
    assert property (life_sign_fault |=> !gate_on)
    else $error("life sign fault left gate on");
  a_soft_plateau:
    assert property ($fell(gate_on) && $past(soft_use) |-> gate_soft_off)
    else $error("two level turn-off skipped");
  a_verify_tmo:
    assert property (verify_timeout |-> $past(verification_state) &&
                     !verification_state)
    else $error("verify timeout without mode");

endmodule : gdf_fault_reaction

// File: gdf_switch_model.sv
// Model of the power switch and its sense comparators at the gate pin.
// Assumes gate_on from the block and fault commands from the bench.
`timescale 1ns/1ns

module gdf_switch_model (
  input  wire logic gate_on,   // Gate drive from the block
  input  wire logic short_cmd, // Bench asks for a shorted load
  input  wire logic ocp_cmd,   // Bench asks for an overcurrent
  output logic      desat_lvl, // Desaturation comparator level
  output logic      ocp_lvl    // Overcurrent comparator level
);
  //////////////////////////////////////////////////////////////////////
  // The collector only desaturates while the switch conducts; when off,
  // the sense pin is clamped low, so a short is invisible then
  assign desat_lvl = gate_on & short_cmd;
  // Shunt current flows only through a conducting switch
  assign ocp_lvl   = gate_on & ocp_cmd;
endmodule : gdf_switch_model

// File: tb.sv
// Self-checking bench of the fault reaction block.
// Assumes the switch model feeds the sense comparator pins.
`timescale 1ns/1ns

module tb;
  localparam int VM0  = 40;      // Short verify timeout, select 0
  localparam int VM1  = 80;      // Short verify timeout, select 1
  localparam int MCT  = 60;      // Short mode change timeout
  localparam int DEAD = 720 / 4; // Least dead time in cycles
  logic              sys_clk   = 1'h0;
  logic              rst       = 1'h1;
  gdf_pkg::gdf_evt_s pins      = '0;       // Bench driven levels
  gdf_pkg::gdf_evt_s pin_bus;              // With comparators merged
  logic [15:0]       blank     = 16'h0000;
  logic [7:0]        clamp     = 8'h00;
  logic [7:0]        two_lvl   = 8'h00;
  logic [6:0]        ctl       = 7'h00;    // sel,ent,exit,dreq,dack,oreq,oack
  logic              fclr      = 1'h0;
  logic              ce        = 1'h1;    // Clock enable
  logic              short_cmd = 1'h0;
  logic              ocp_cmd   = 1'h0;
  logic              desat_lvl;
  logic              ocp_lvl;
  wire  [9:0]        obs;                  // Outputs, gate_on at bit 9
  int                errors      = 0;
  int                checks_done = 0;

  //////////////////////////////////////////////////////////////////////
  // Clock and pin merge
  always #2 sys_clk = ~sys_clk;
  always_comb begin
    pin_bus                   = pins;
    pin_bus.desat_in          = desat_lvl;
    pin_bus.overcurrent_input = ocp_lvl;
  end

  gdf_fault_reaction #(.VMTO0_CYC(VM0), .VMTO1_CYC(VM1), .MCTO_CYC(MCT))
  i_dut (
    .sys_clk(sys_clk), .rst(rst), .ce(ce), .pin_evt(pin_bus),
    .blank_cycles(blank), .clamp_delay_setting(clamp),
    .two_level_turnoff_time(two_lvl), .verify_timeout_select(ctl[6]),
    .verify_enter(ctl[5]), .verify_exit(ctl[4]),
    .desat_mode_req(ctl[3]), .desat_mode_ack(ctl[2]),
    .ovlo_mode_req(ctl[1]), .ovlo_mode_ack(ctl[0]), .fault_clear(fclr),
    .gate_on(obs[9]), .gate_soft_off(obs[8]),
    .fault_class_a_pin(obs[7]), .fault_class_b_pin(obs[6]),
    .fault_latched(obs[5]), .life_sign_fault(obs[4]),
    .verification_state(obs[3]), .verify_timeout(obs[2]),
    .desat_mode_timeout(obs[1]), .ovlo_mode_timeout(obs[0]));

  gdf_switch_model i_sw (
    .gate_on(obs[9]), .short_cmd(short_cmd), .ocp_cmd(ocp_cmd),
    .desat_lvl(desat_lvl), .ocp_lvl(ocp_lvl));

  //////////////////////////////////////////////////////////////////////
  // Shared helpers; drives land 1 ns after the rising edge
  task automatic tick(input int n);
    repeat (n) @(posedge sys_clk);
    #1;
  endtask : tick

  task automatic chk_val(input logic [9:0] act, input logic [9:0] exp,
                         input string m);
    checks_done++;
    if (act !== exp) begin
      errors++;
      $display("[ERR] %0t %s", $time, m);
    end
  endtask : chk_val

  task automatic chk_rng(input int n, input int lo, input int hi,
                         input string m);
    checks_done++;
    if (n < lo || n > hi) begin
      errors++;
      $display("[ERR] %0t %s, got %0d", $time, m, n);
    end
  endtask : chk_rng

  // Counts edges until an output reaches lvl; bounded so a hang ends
  task automatic wait_bit(input int idx, input logic lvl, input int lim,
                          output int n);
    n = 0;
    do begin
      tick(1);
      n++;
    end while (obs[idx] !== lvl && n < lim);
  endtask : wait_bit

  task automatic go_on(input logic [7:0] c);
    int n;
    clamp = c;
    pins.pwm_cmd = 1'h1;
    wait_bit(9, 1'h1, 400, n);
    chk_rng(n, 3 + DEAD + c, 3 + DEAD + c, "turn-on delay");
  endtask : go_on

  // Drops all events, lets any plateau end, then clears sticky flags
  task automatic settle();
    pins = 9'h080; // Every event low, enable high
    short_cmd = 1'h0;
    ocp_cmd = 1'h0;
    tick(12);
    fclr = 1'h1;
    tick(1);
    fclr = 1'h0;
    tick(2);
    chk_val(obs, 10'h000, "not idle after clear");
  endtask : settle

  //////////////////////////////////////////////////////////////////////
  // Scenarios
  task automatic t_dead();
    go_on(8'h00);
    settle();
    go_on(8'h05);
    settle();
  endtask : t_dead

  task automatic t_enable();
    int n;
    go_on(8'h00);
    pins.enable_in = 1'h0;
    wait_bit(9, 1'h0, 120, n);
    chk_rng(n, 3, 3, "enable off delay");
    chk_val(obs[5], 1'h0, "enable removal latched a fault");
    settle();
  endtask : t_enable

  // Class B, low side and high side failures, last one with a plateau
  task automatic t_fail();
    int k;
    int n;
    int m;
    for (int i = 0; i < 3; i++) begin
      k = 3 - i;
      two_lvl = (k == 1) ? 8'h04 : 8'h00;
      go_on(8'h00);
      pins[k] = 1'h1;
      wait_bit(9, 1'h0, 120, n);
      chk_rng(n, 3, 3, "failure off delay");
      chk_val(obs[5], 1'h1, "fault not latched");
      chk_val(obs[6], k == 3, "class B pin wrong");
      chk_val(obs[8], k == 1, "plateau wrong");
      wait_bit(8, 1'h0, 20, m);
      chk_rng(m, (k == 1) ? 4 : 1, (k == 1) ? 5 : 1, "plateau");
      tick(200);
      chk_val(obs[9], 1'h0, "gate back on while latched");
      settle();
    end
    two_lvl = 8'h00;
  endtask : t_fail

  task automatic t_class_a();
    int n;
    go_on(8'h00);
    pins.class_a_evt = 1'h1;
    wait_bit(7, 1'h1, 1300, n);
    chk_rng(n, 1, 1250, "class A pin delay");
    chk_val(obs[9], 1'h1, "class A alone stopped gate");
    settle();
  endtask : t_class_a

  task automatic t_life();
    int n;
    int m;
    go_on(8'h00);
    pins.life_sign_err = 1'h1;
    wait_bit(4, 1'h1, 1400, n);
    chk_rng(n, 1248, 1256, "life sign recognition");
    wait_bit(9, 1'h0, 120, m);
    chk_rng(m, 1, 107, "life sign off delay");
    settle();
  endtask : t_life

  // Comparator trips at once but must wait out 1 us of blanking
  task automatic t_blank();
    int n;
    blank = 16'h00FA;
    for (int s = 0; s < 2; s++) begin
      short_cmd = (s == 0);
      ocp_cmd = (s == 1);
      go_on(8'h00);
      wait_bit(9, 1'h0, 200, n);
      chk_rng(183 + n, 202, 305, "blanking end");
      chk_val(obs[7], 1'h1, "class A pin not set on trip");
      settle();
    end
    blank = 16'h0000;
  endtask : t_blank

  task automatic t_verify();
    int n;
    int lim;
    for (int s = 0; s < 2; s++) begin
      lim = s ? VM1 : VM0;
      ctl[6] = s[0];
      ctl[5] = 1'h1;
      tick(1);
      ctl[5] = 1'h0;
      wait_bit(2, 1'h1, 200, n);
      chk_rng(n, lim, lim + 2, "verify timeout");
      chk_val(obs[3], 1'h0, "verify mode not left");
    end
    ctl[5] = 1'h1;
    tick(1);
    ctl[5] = 1'h0;
    tick(10);
    ctl[4] = 1'h1;
    tick(1);
    ctl[4] = 1'h0;
    wait_bit(2, 1'h1, 2 * VM1, n);
    chk_rng(n, 2 * VM1, 2 * VM1, "exit did not cancel");
  endtask : t_verify

  task automatic t_modes();
    int n;
    for (int m = 0; m < 2; m++) begin
      ctl[3 - 2 * m] = 1'h1;
      tick(1);
      ctl[3 - 2 * m] = 1'h0;
      wait_bit(1 - m, 1'h1, 200, n);
      chk_rng(n, MCT, MCT + 2, "mode timeout");
      ctl[3 - 2 * m] = 1'h1;
      tick(1);
      ctl[3 - 2 * m] = 1'h0;
      tick(5);
      ctl[2 - 2 * m] = 1'h1;
      tick(1);
      ctl[2 - 2 * m] = 1'h0;
      wait_bit(1 - m, 1'h1, 2 * MCT, n);
      chk_rng(n, 2 * MCT, 2 * MCT, "ack did not cancel");
    end
  endtask : t_modes

  // Clock enable low must hold a running timer where it stands
  task automatic t_freeze();
    int n;
    ctl[3] = 1'h1;
    tick(1);
    ctl[3] = 1'h0;
    ce = 1'h0;
    tick(20);
    ce = 1'h1;
    wait_bit(1, 1'h1, 200, n);
    chk_rng(n, MCT, MCT, "clock enable did not freeze");
  endtask : t_freeze

  //////////////////////////////////////////////////////////////////////
  // Verdict, main sequence and watchdog
  task automatic print_verdict();
    if (errors == 0 && checks_done > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask : print_verdict

  initial begin
    pins.enable_in = 1'h1;
    tick(6);
    rst = 1'h0;
    chk_val(obs, 10'h000, "outputs not cleared by reset");
    t_dead();
    t_enable();
    t_fail();
    t_class_a();
    t_life();
    t_blank();
    t_verify();
    t_modes();
    t_freeze();
    print_verdict();
  end

  // About 4800 cycles are expected; allow a wide margin
  initial begin
    #80000;
    errors++;
    $display("[ERR] %0t watchdog expired", $time);
    print_verdict();
  end
endmodule : tb
